// ===== sas_map.vh
// constants for the sdram access sequencer: command codes, field codes, wait figures
`ifndef SAS_MAP_VH
`define SAS_MAP_VH

// ***********************************************
// command codes on {row strobe, column strobe, write enable}
// ***********************************************
`define SAS_CMD_NOP         3'h7
`define SAS_CMD_ACT         3'h3
`define SAS_CMD_RD          3'h5
`define SAS_CMD_WR          3'h4
`define SAS_CMD_PRE         3'h2
`define SAS_CMD_REF         3'h1

// ***********************************************
// per-space and per-lane field widths and codes
// ***********************************************
`define SAS_BCW_W           2
`define SAS_LAT_W           3
`define SAS_SSO_W           2
`define SAS_SSO_8           2'h0
`define SAS_SSO_16          2'h1
`define SAS_SSO_32          2'h2
`define SAS_LANE_MODE_WR    1'b0
`define SAS_LANE_MODE_BE    1'b1

// ***********************************************
// wait figures
// ***********************************************
`define SAS_REF_WAIT_SHIFT  2
`define SAS_INIT_WAITS      4'h3
`define SAS_AUX_PALL        11'h400

`endif

// ===== sas_sync.v
// two-flop synchroniser for levels entering the CLOCK domain
`timescale 1ns/1ps
module sas_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // sas_sync

// ===== sas_sequencer.v
// sdram access sequencer: activate/read/write/precharge/refresh with per-space timing
//
// Behaviour
// - write to a closed row: activate, then write
// - write to the open row: write only, no precharge or activate
// - other row in the same bank: precharge that bank before activate
// - no external wait input; cycle length set only by timing fields
// - bank-cycle wait code gives 1..3 waits from activate to read/write
// - same code gives 1..3 waits from precharge to next activate
// - read data sampled after latency 1, 2 or 3 bus clocks
// - after refresh wait four times the bank-cycle code: 4, 8, 12
// - one intercycle state before the command state of every access cycle; refresh goes from idle straight to precharge-all
// - auxiliary address bit on top line for 32-bit, A11 16-bit, A10 8-bit
// - lane mode 0 gives write strobes, mode 1 gives byte enables
// - a cpu store or two-cycle dma write starts one write cycle
// - four per-lane mask outputs driven in command and data states
// - separate timing set for each of spaces 1, 3, 4 and 6
// - all-bank precharge at power-on and refresh; next access activates
// - bank change: activate new, command, then precharge old bank
// - reads hold a late state after the command until the data is captured
`timescale 1ns/1ps
`include "sas_map.vh"
module sas_sequencer #(
    parameter DATA_W = 32,
    parameter LANES  = 4,
    parameter ROW_W  = 11,
    parameter COL_W  = 10
) (
    input  wire                CLOCK,
    input  wire                RST,
    input  wire                EXTERNAL_BUS_CLOCK,
    input  wire                REQ_VALID,
    input  wire                REQ_WRITE,
    input  wire [1:0]          REQ_SPACE,
    input  wire [1:0]          REQ_BANK,
    input  wire [ROW_W-1:0]    REQ_ROW,
    input  wire [COL_W-1:0]    REQ_COL,
    input  wire [LANES-1:0]    REQ_LANES,
    input  wire [DATA_W-1:0]   REQ_WDATA,
    input  wire [3:0]          REFRESH_REQ,
    input  wire [7:0]          BANK_CYCLE_WAIT,
    input  wire [11:0]         READ_LATENCY_SEL,
    input  wire [7:0]          BUS_WIDTH_SEL,
    input  wire [LANES-1:0]    LANE_STROBE_MODE_SEL,
    input  wire [DATA_W-1:0]   DQ_IN,
    output reg                 REQ_READY,
    output reg                 RSP_VALID,
    output reg  [DATA_W-1:0]   RSP_RDATA,
    output reg  [3:0]          REFRESH_ACK,
    output reg  [3:0]          SPACE_SELECT_N,
    output reg                 ROW_STROBE_N,
    output reg                 COLUMN_STROBE_N,
    output reg                 WRITE_ENABLE_N,
    output reg  [1:0]          BANK_ADDR,
    output reg  [ROW_W+1:0]    ADDR,
    output reg                 BUS_CYCLE_START,
    output reg  [LANES-1:0]    BYTE_LANE_STROBE_N,
    output reg  [LANES-1:0]    BYTE_MASK_OUT,
    output reg  [DATA_W-1:0]   DQ_OUT,
    output reg                 DQ_OE_N
);

    // ***********************************************
    // states
    // ***********************************************
    localparam [10:0] ST_INIT = 11'h001;
    localparam [10:0] ST_IDLE = 11'h002;
    localparam [10:0] ST_T0   = 11'h004;
    localparam [10:0] ST_PRE  = 11'h008;
    localparam [10:0] ST_PALL = 11'h010;
    localparam [10:0] ST_ACT  = 11'h020;
    localparam [10:0] ST_WAIT = 11'h040;
    localparam [10:0] ST_CMD  = 11'h080;
    localparam [10:0] ST_LATE = 11'h100;
    localparam [10:0] ST_REF  = 11'h200;
    localparam [10:0] ST_BPRE = 11'h400;

    // ***********************************************
    // bus clock edges
    // ***********************************************
    wire              bclk_sync;
    wire [DATA_W-1:0] dq_sync;
    reg               bclk_last;
    wire              rise_tick = bclk_sync & ~bclk_last;
    // outputs change at the falling edge so the device sees them stable at rising
    wire              fall_tick = ~bclk_sync & bclk_last;

    sas_sync #(.W(1)) u_bclk_sync (
        .clk (CLOCK),
        .rst (RST),
        .d   (EXTERNAL_BUS_CLOCK),
        .q   (bclk_sync)
    );

    sas_sync #(.W(DATA_W)) u_dq_sync (
        .clk (CLOCK),
        .rst (RST),
        .d   (DQ_IN),
        .q   (dq_sync)
    );

    // ***********************************************
    // latched request and open-row bookkeeping
    // ***********************************************
    reg  [10:0]       state;
    reg  [10:0]       next_state;
    reg  [10:0]       wait_tgt;
    reg  [3:0]        wait_cnt;
    reg  [3:0]        lat_cnt;
    reg               pending;
    reg               captured;
    reg               refreshing;
    reg               init_phase;
    reg               bank_change;
    reg  [1:0]        old_bank;
    reg  [1:0]        cur_sp;
    reg  [1:0]        ref_slot;
    reg               cur_wr;
    reg  [1:0]        cur_bank;
    reg  [ROW_W-1:0]  cur_row;
    reg  [COL_W-1:0]  cur_col;
    reg  [LANES-1:0]  cur_lanes;
    reg  [DATA_W-1:0] cur_wdata;
    reg  [3:0]        open_valid;
    reg  [1:0]        open_bank [0:3];
    reg  [ROW_W-1:0]  open_row  [0:3];

    // each space keeps its own timing fields
    wire [1:0] bcw = BANK_CYCLE_WAIT[{(refreshing ? ref_slot : cur_sp), 1'b0} +: `SAS_BCW_W];
    wire [2:0] lat = READ_LATENCY_SEL[cur_sp * 3 +: `SAS_LAT_W];
    wire [1:0] sso = BUS_WIDTH_SEL[{cur_sp, 1'b0} +: `SAS_SSO_W];

    // lowest requesting space wins the refresh slot
    wire [1:0] ref_sp = REFRESH_REQ[0] ? 2'h0 : REFRESH_REQ[1] ? 2'h1 :
                        REFRESH_REQ[2] ? 2'h2 : 2'h3;

    wire row_open  = open_valid[cur_sp];
    wire same_bank = open_bank[cur_sp] == cur_bank;
    wire same_row  = open_row[cur_sp] == cur_row;

    // ***********************************************
    // wait length and target of the current command state
    // ***********************************************
    reg [3:0]  wait_len;
    reg [10:0] tgt;

    always @* begin
        wait_len = {2'h0, bcw};
        tgt      = ST_IDLE;
        case (state)
            ST_INIT: begin
                wait_len = 4'h0;
            end
            ST_PALL: begin
                wait_len = init_phase ? `SAS_INIT_WAITS : {2'h0, bcw};
                tgt      = init_phase ? ST_IDLE : ST_REF;
            end
            ST_PRE: begin
                tgt = ST_ACT;
            end
            ST_ACT: begin
                tgt = ST_CMD;
            end
            ST_REF: begin
                wait_len = {bcw, 2'h0};
            end
            default: begin
                tgt = ST_IDLE;
            end
        endcase
        // reserved code 00 simply yields no wait; software must not use it
    end

    // ***********************************************
    // next state
    // ***********************************************
    always @* begin
        next_state = state;
        case (state)
            ST_INIT: begin
                next_state = ST_PALL;
            end
            ST_IDLE: begin
                if (|REFRESH_REQ) begin
                    next_state = ST_PALL;
                end else if (pending) begin
                    next_state = ST_T0;
                end
            end
            ST_T0: begin
                if (!row_open) begin
                    next_state = ST_ACT;
                end else if (same_bank && same_row) begin
                    next_state = ST_CMD;
                end else if (same_bank) begin
                    next_state = ST_PRE;
                end else begin
                    next_state = ST_ACT;
                end
            end
            ST_PRE, ST_PALL, ST_ACT, ST_REF, ST_BPRE: begin
                next_state = (wait_len == 4'h0) ? tgt : ST_WAIT;
            end
            ST_WAIT: begin
                if (wait_cnt == 4'h1) begin
                    next_state = wait_tgt;
                end
            end
            ST_CMD: begin
                if (!cur_wr) begin
                    next_state = ST_LATE;
                end else begin
                    next_state = bank_change ? ST_BPRE : ST_IDLE;
                end
            end
            ST_LATE: begin
                if (captured) begin
                    next_state = bank_change ? ST_BPRE : ST_IDLE;
                end
            end
            default: begin
                next_state = ST_INIT;
            end
        endcase
    end

    // ***********************************************
    // request side and read capture (every CLOCK)
    // ***********************************************
    // there is no wait-request input: sdram cycles never stretch from outside
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= {DATA_W{1'b0}};
            pending   <= 1'b0;
            captured  <= 1'b0;
            lat_cnt   <= 4'h0;
            bclk_last <= 1'b0;
            cur_wr    <= 1'b0;
            cur_sp    <= 2'h0;
            ref_slot  <= 2'h0;
            cur_bank  <= 2'h0;
            cur_row   <= {ROW_W{1'b0}};
            cur_col   <= {COL_W{1'b0}};
            cur_lanes <= {LANES{1'b0}};
            cur_wdata <= {DATA_W{1'b0}};
        end else begin
            bclk_last <= bclk_sync;
            RSP_VALID <= 1'b0;
            if (REQ_VALID && REQ_READY) begin
                REQ_READY <= 1'b0;
                pending   <= 1'b1;
                cur_wr    <= REQ_WRITE;
                cur_sp    <= REQ_SPACE;
                cur_bank  <= REQ_BANK;
                cur_row   <= REQ_ROW;
                cur_col   <= REQ_COL;
                cur_lanes <= REQ_LANES;
                cur_wdata <= REQ_WDATA;
            end
            // refresh keeps its own space so a waiting access is not redirected
            if (fall_tick && state == ST_IDLE && |REFRESH_REQ) begin
                ref_slot  <= ref_sp;
                REQ_READY <= 1'b0;
            end
            if (fall_tick && state == ST_IDLE && ~|REFRESH_REQ && pending) begin
                pending <= 1'b0;
            end
            if (fall_tick && next_state == ST_IDLE && state != ST_IDLE && !pending) begin
                REQ_READY <= 1'b1;
            end
            if (fall_tick && state == ST_CMD && cur_wr) begin
                RSP_VALID <= 1'b1;
            end
            if (fall_tick && next_state == ST_CMD && state != ST_CMD) begin
                lat_cnt  <= {1'b0, lat} + 4'h1;
                captured <= 1'b0;
            end else if (rise_tick && !cur_wr && (state == ST_CMD || state == ST_LATE)
                         && !captured) begin
                if (lat_cnt == 4'h1) begin
                    RSP_RDATA <= dq_sync;
                    RSP_VALID <= 1'b1;
                    captured  <= 1'b1;
                end else begin
                    lat_cnt <= lat_cnt - 4'h1;
                end
            end
        end
    end

    // ***********************************************
    // sequencer and pins (on the bus clock falling edge)
    // ***********************************************
    wire [LANES-1:0] next_lane_strobe_n;
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi = gi + 1) begin : g_lane
            // write strobes only pulse on writes; byte enables cover reads too
            assign next_lane_strobe_n[gi] = ~(cur_lanes[gi] &
                (LANE_STROBE_MODE_SEL[gi] == `SAS_LANE_MODE_BE | cur_wr));
        end
    endgenerate

    function [ROW_W+1:0] place_addr;
        input [ROW_W-1:0] v;
        input [1:0]       width;
        begin
            if (width == `SAS_SSO_8) begin
                place_addr = {2'h0, v};
            end else if (width == `SAS_SSO_16) begin
                place_addr = {1'b0, v, 1'b0};
            end else begin
                place_addr = {v, 2'h0};
            end
        end
    endfunction

    reg [1:0] sp_slot;
    always @* begin
        sp_slot = refreshing ? ref_slot : cur_sp;
    end

    integer k;
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state              <= ST_INIT;
            wait_cnt           <= 4'h0;
            wait_tgt           <= ST_IDLE;
            refreshing         <= 1'b0;
            init_phase         <= 1'b1;
            bank_change        <= 1'b0;
            old_bank           <= 2'h0;
            open_valid         <= 4'h0;
            REFRESH_ACK        <= 4'h0;
            SPACE_SELECT_N     <= 4'hf;
            {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N} <= `SAS_CMD_NOP;
            BANK_ADDR          <= 2'h0;
            ADDR               <= {(ROW_W+2){1'b0}};
            BUS_CYCLE_START    <= 1'b0;
            BYTE_LANE_STROBE_N <= {LANES{1'b1}};
            BYTE_MASK_OUT      <= {LANES{1'b1}};
            DQ_OUT             <= {DATA_W{1'b0}};
            DQ_OE_N            <= 1'b1;
            for (k = 0; k < 4; k = k + 1) begin
                open_bank[k] <= 2'h0;
                open_row[k]  <= {ROW_W{1'b0}};
            end
        end else begin
            REFRESH_ACK <= 4'h0;
            if (fall_tick) begin
                state <= next_state;
                if (next_state == ST_WAIT && state != ST_WAIT) begin
                    wait_cnt <= wait_len;
                    wait_tgt <= tgt;
                end else if (state == ST_WAIT) begin
                    wait_cnt <= wait_cnt - 4'h1;
                end
                SPACE_SELECT_N     <= 4'hf;
                {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N} <= `SAS_CMD_NOP;
                BUS_CYCLE_START    <= 1'b0;
                BYTE_LANE_STROBE_N <= {LANES{1'b1}};
                BYTE_MASK_OUT      <= {LANES{1'b1}};
                DQ_OE_N            <= 1'b1;
                if (state == ST_T0) begin
                    BUS_CYCLE_START <= 1'b1;
                    bank_change     <= row_open && !same_bank;
                    old_bank        <= open_bank[sp_slot];
                end
                case (next_state)
                    ST_PALL: begin
                        SPACE_SELECT_N <= init_phase ? 4'h0 : ~(4'h1 << ref_sp);
                        {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N} <= `SAS_CMD_PRE;
                        ADDR       <= place_addr(`SAS_AUX_PALL, sso);
                        refreshing <= !init_phase;
                        if (init_phase) begin
                            open_valid <= 4'h0;
                        end else begin
                            open_valid[ref_sp] <= 1'b0;
                        end
                    end
                    ST_PRE, ST_BPRE: begin
                        SPACE_SELECT_N[sp_slot] <= 1'b0;
                        {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N} <= `SAS_CMD_PRE;
                        BANK_ADDR <= (next_state == ST_BPRE) ? old_bank : cur_bank;
                        ADDR      <= {(ROW_W+2){1'b0}};
                    end
                    ST_ACT: begin
                        SPACE_SELECT_N[sp_slot] <= 1'b0;
                        {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N} <= `SAS_CMD_ACT;
                        BANK_ADDR           <= cur_bank;
                        ADDR                <= place_addr(cur_row, sso);
                        open_valid[sp_slot] <= 1'b1;
                        open_bank[sp_slot]  <= cur_bank;
                        open_row[sp_slot]   <= cur_row;
                        BYTE_MASK_OUT       <= ~cur_lanes;
                    end
                    ST_CMD: begin
                        SPACE_SELECT_N[sp_slot] <= 1'b0;
                        {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N} <=
                            cur_wr ? `SAS_CMD_WR : `SAS_CMD_RD;
                        BANK_ADDR          <= cur_bank;
                        ADDR               <= place_addr({1'b0, cur_col}, sso);
                        BYTE_MASK_OUT      <= ~cur_lanes;
                        BYTE_LANE_STROBE_N <= next_lane_strobe_n;
                        DQ_OUT             <= cur_wdata;
                        DQ_OE_N            <= ~cur_wr;
                    end
                    ST_LATE: begin
                        BYTE_MASK_OUT      <= ~cur_lanes;
                        BYTE_LANE_STROBE_N <= next_lane_strobe_n;
                    end
                    ST_REF: begin
                        SPACE_SELECT_N[sp_slot] <= 1'b0;
                        {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N} <= `SAS_CMD_REF;
                        REFRESH_ACK[sp_slot]    <= 1'b1;
                    end
                    ST_WAIT: begin
                        if (state == ST_ACT || (state == ST_WAIT && wait_tgt == ST_CMD)) begin
                            BYTE_MASK_OUT <= ~cur_lanes;
                        end
                    end
                    ST_IDLE: begin
                        init_phase <= 1'b0;
                        refreshing <= 1'b0;
                    end
                    default: begin
                        init_phase <= init_phase;
                    end
                endcase
            end
        end
    end

endmodule // sas_sequencer

// ===== sas_seq_asserts.sv
// pin-level checker for the sdram access sequencer
`timescale 1ns/1ps
`include "sas_map.vh"
module sas_seq_asserts (
    input wire       CLOCK,
    input wire       RST,
    input wire [7:0] BANK_CYCLE_WAIT,
    input wire [3:0] LANE_STROBE_MODE_SEL,
    input wire [3:0] REFRESH_ACK,
    input wire [3:0] SPACE_SELECT_N,
    input wire       ROW_STROBE_N,
    input wire       COLUMN_STROBE_N,
    input wire       WRITE_ENABLE_N,
    input wire       BUS_CYCLE_START,
    input wire [3:0] BYTE_LANE_STROBE_N,
    input wire [3:0] BYTE_MASK_OUT,
    input wire       DQ_OE_N
);
    reg  [2:0] prev;
    reg  [2:0] last;
    reg  [7:0] nop_cnt;
    wire [2:0] cmd = {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N};
    wire [1:0] idx = !SPACE_SELECT_N[0] ? 2'h0 : !SPACE_SELECT_N[1] ? 2'h1 :
                     !SPACE_SELECT_N[2] ? 2'h2 : 2'h3;
    wire [8:0] w8  = {BANK_CYCLE_WAIT[{idx, 1'b0} +: 2], 3'h0};
    wire       st  = cmd != `SAS_CMD_NOP && prev == `SAS_CMD_NOP;
    // nop run length before each command, so gaps can be tied to the wait code
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            prev    <= `SAS_CMD_NOP;
            last    <= `SAS_CMD_NOP;
            nop_cnt <= 8'h00;
        end else begin
            prev <= cmd;
            if (cmd != `SAS_CMD_NOP) begin
                last    <= cmd;
                nop_cnt <= 8'h00;
            end else if (nop_cnt != 8'hff) begin
                nop_cnt <= nop_cnt + 8'h01;
            end
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    a_cmd_legal: assert property (cmd != 3'h0 && cmd != 3'h6)
        else $error("undefined command code");
    a_act_wait: assert property (st && last == `SAS_CMD_ACT |->
        nop_cnt + 9'h1 >= w8 && nop_cnt <= w8 + 9'h1) else $error("activate wait wrong");
    a_pre_wait: assert property (st && last == `SAS_CMD_PRE |-> nop_cnt + 9'h1 >= w8)
        else $error("precharge wait short");
    a_ref_wait: assert property (st && last == `SAS_CMD_REF |->
        nop_cnt + 11'h1 >= {w8, 2'h0}) else $error("refresh wait short");
    a_dq_drive: assert property (!DQ_OE_N |-> cmd == `SAS_CMD_WR)
        else $error("data driven outside write");
    a_rd_strobe: assert property (cmd == `SAS_CMD_RD |->
        &(BYTE_LANE_STROBE_N | LANE_STROBE_MODE_SEL)) else $error("write strobe on read");
    a_ref_ack: assert property (|REFRESH_ACK |-> ##[0:1] cmd == `SAS_CMD_REF)
        else $error("refresh ack without refresh");
    a_cycle_start: assert property (BUS_CYCLE_START |-> cmd != `SAS_CMD_NOP)
        else $error("cycle start without command");
    a_wr_mask: assert property (cmd == `SAS_CMD_WR |-> BYTE_MASK_OUT == BYTE_LANE_STROBE_N)
        else $error("write mask differs from lane strobes");
    c_act: cover property (st && last == `SAS_CMD_ACT);
    c_ref: cover property (|REFRESH_ACK);
    c_rd: cover property (cmd == `SAS_CMD_RD);
endmodule // sas_seq_asserts
bind sas_sequencer sas_seq_asserts u_chk (.CLOCK, .RST, .BANK_CYCLE_WAIT,
    .LANE_STROBE_MODE_SEL, .REFRESH_ACK, .SPACE_SELECT_N, .ROW_STROBE_N,
    .COLUMN_STROBE_N, .WRITE_ENABLE_N, .BUS_CYCLE_START, .BYTE_LANE_STROBE_N, .BYTE_MASK_OUT,
    .DQ_OE_N);

// ===== sas_sdram_model.sv
// behavioural sdram on the chip-select bus, with its free-running bus clock
`timescale 1ns/1ps
`include "sas_map.vh"
module sas_sdram_model (
    output reg         bclk,
    output reg  [31:0] dq_in,
    input  wire [3:0]  select_n,
    input  wire [2:0]  cmd,
    input  wire [12:0] addr,
    input  wire [31:0] dq_out,
    input  wire        dq_oe_n,
    input  wire [11:0] lat_sel
);
    reg  [31:0] mem [0:15];
    reg  [3:0]  col;
    reg  [2:0]  cnt;
    wire [1:0]  idx = !select_n[0] ? 2'h0 : !select_n[1] ? 2'h1 : !select_n[2] ? 2'h2 : 2'h3;
    initial begin
        bclk = 1'b0;
        dq_in = 32'h0;
        cnt = 3'h0;
        #13;
        forever #32 bclk = ~bclk;
    end
    always @(posedge bclk) begin
        if (cnt != 3'h0)
            cnt = cnt - 3'h1;
        if (select_n != 4'hf && cmd == `SAS_CMD_WR && !dq_oe_n)
            mem[addr[5:2]] = dq_out;
        if (select_n != 4'hf && cmd == `SAS_CMD_RD) begin
            col = addr[5:2];
            cnt = lat_sel[idx * 3 +: 3];
        end
        if (cnt == 3'h1)
            dq_in = mem[col];
    end
    // released lines flip every period so stale data never passes for a match
    always @(negedge bclk)
        if (cnt == 3'h0)
            dq_in = ~dq_in;
endmodule // sas_sdram_model

// ===== testbench.sv
// self-checking bench for the sdram access sequencer
`timescale 1ns/1ps
`include "sas_map.vh"
module testbench;
    reg         clock, rst, req_valid, req_write;
    reg  [1:0]  req_space, req_bank;
    reg  [10:0] req_row;
    reg  [9:0]  req_col;
    reg  [31:0] req_wdata;
    reg  [3:0]  refresh_req;
    reg  [11:0] lat_sel = 12'h4d1;
    reg  [2:0]  prev = 3'h7;
    reg  [2:0]  cmds [$];
    wire        bus_clk, req_ready, rsp_valid, dq_oe_n;
    wire [31:0] rsp_rdata, dq_in, dq_out;
    wire [3:0]  refresh_ack, space_select_n;
    wire [2:0]  cmd;
    wire [12:0] addr;
    integer     n_mismatch = 0;
    integer     tests_run = 0;
    integer     s;
    // latency one sits on space index 0, which carries no flyby traffic
    sas_sequencer u_dut (.CLOCK(clock), .RST(rst), .EXTERNAL_BUS_CLOCK(bus_clk),
        .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_SPACE(req_space),
        .REQ_BANK(req_bank), .REQ_ROW(req_row), .REQ_COL(req_col), .REQ_LANES(4'hf),
        .REQ_WDATA(req_wdata), .REFRESH_REQ(refresh_req), .BANK_CYCLE_WAIT(8'h79),
        .READ_LATENCY_SEL(lat_sel), .BUS_WIDTH_SEL(8'haa), .LANE_STROBE_MODE_SEL(4'h5),
        .DQ_IN(dq_in), .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .REFRESH_ACK(refresh_ack), .SPACE_SELECT_N(space_select_n), .ROW_STROBE_N(cmd[2]),
        .COLUMN_STROBE_N(cmd[1]), .WRITE_ENABLE_N(cmd[0]), .BANK_ADDR(), .ADDR(addr),
        .BUS_CYCLE_START(), .BYTE_LANE_STROBE_N(), .BYTE_MASK_OUT(), .DQ_OUT(dq_out),
        .DQ_OE_N(dq_oe_n));
    sas_sdram_model u_mem (.bclk(bus_clk), .dq_in(dq_in), .select_n(space_select_n),
        .cmd(cmd), .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .lat_sel(lat_sel));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        if (cmd != prev && cmd != `SAS_CMD_NOP)
            cmds.push_back(cmd);
        prev <= cmd;
    end
    task test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task compare(input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task check_cmds(input [11:0] exp);
        reg [11:0] got;
        got = 12'h0;
        foreach (cmds[k])
            got = {got[8:0], cmds[k]};
        compare({20'h0, got}, {20'h0, exp});
        cmds.delete();
    endtask
    task wait_on(input integer k);
        integer t;
        t = 0;
        while (t < 3000 && (k == 0 ? req_ready : k == 1 ? rsp_valid : refresh_ack[0]) !== 1'b1)
        begin
            @(negedge clock);
            t = t + 1;
        end
        if (t == 3000) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0t: wait %0d timed out", $time, k);
        end
    endtask
    task access(input w, input [1:0] sp, input [1:0] bk, input [10:0] row,
                input [9:0] col, input [31:0] d);
        @(negedge clock);
        wait_on(0);
        req_valid = 1'b1;
        req_write = w;
        {req_space, req_bank, req_row, req_col, req_wdata} = {sp, bk, row, col, d};
        @(negedge clock);
        req_valid = 1'b0;
        wait_on(1);
        if (!w)
            compare(rsp_rdata, d);
        wait_on(0);
    endtask
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        test_done;
    end
    initial begin
        rst = 1'b1;
        {req_valid, req_write, req_space, req_bank, req_row, req_col, req_wdata} = 59'h0;
        refresh_req = 4'h0;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        access(1'b1, 2'h0, 2'h0, 11'h005, 10'h001, 32'ha5a5_0001);
        check_cmds({`SAS_CMD_PRE, `SAS_CMD_ACT, `SAS_CMD_WR});
        access(1'b1, 2'h0, 2'h0, 11'h005, 10'h002, 32'ha5a5_0002);
        check_cmds(`SAS_CMD_WR);
        access(1'b0, 2'h0, 2'h0, 11'h005, 10'h001, 32'ha5a5_0001);
        check_cmds(`SAS_CMD_RD);
        access(1'b1, 2'h0, 2'h0, 11'h006, 10'h003, 32'ha5a5_0003);
        check_cmds({`SAS_CMD_PRE, `SAS_CMD_ACT, `SAS_CMD_WR});
        access(1'b0, 2'h0, 2'h1, 11'h006, 10'h003, 32'ha5a5_0003);
        check_cmds({`SAS_CMD_ACT, `SAS_CMD_RD, `SAS_CMD_PRE});
        @(negedge clock);
        refresh_req = 4'h1;
        wait_on(2);
        refresh_req = 4'h0;
        wait_on(0);
        check_cmds({`SAS_CMD_PRE, `SAS_CMD_REF});
        access(1'b0, 2'h0, 2'h0, 11'h006, 10'h003, 32'ha5a5_0003);
        check_cmds({`SAS_CMD_ACT, `SAS_CMD_RD});
        for (s = 1; s < 3; s = s + 1) begin
            access(1'b1, s[1:0], 2'h0, 11'h001, 10'h004 + s[9:0], 32'h5a5a_0000 + s);
            check_cmds({`SAS_CMD_ACT, `SAS_CMD_WR});
            access(1'b0, s[1:0], 2'h0, 11'h001, 10'h004 + s[9:0], 32'h5a5a_0000 + s);
            check_cmds(`SAS_CMD_RD);
        end
        test_done;
    end
endmodule // testbench
